// file: rtl/manchester_codec.sv
// Contract
// - Strobe low disables receiver; high passes traffic
// - Both power inputs jointly set transmitter state
// - Standby only when both low; receiver not affected by standby
// - Envelope rises after first half bit, falls after last
// - One recovered clock pulse per received bit; a bit that arrives with the buffer full is dropped and gets none
// - Recovered data valid at recovered clock rise
// - Controller gives shift clock, high first half
// - Encode NRZ to Manchester on gated clock
// - Envelope high to send, low before final edge
// - Two gated edges per bit, 25ns and 75ns
// - One extra gated edge ends the transmission
// - Master reset low clears encoder; pulse max 15ns
`timescale 1ns/1ps
`default_nettype none

module manchester_codec (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  manchester_link_if.device_end       link,
  input  wire logic                   line_in,
  output logic                        line_out,
  output logic                        line_oe_n,
  output logic                        tx_standby,
  output logic                        rx_overrun
);

  // ---------------- Encoder ----------------
  logic gck_prev;
  logic gck_rise;
  logic held_bit;
  logic standby;

  assign gck_rise = link.gated_clk & ~gck_prev;
  assign standby  = ~link.encoder_enable & ~link.power_mgmt;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      gck_prev <= 1'b0;
    else
      gck_prev <= link.gated_clk;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tx_standby <= 1'b1;
    else
      tx_standby <= standby;
  end

  // Shift clock level tells which half of the cell the edge opens
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_out  <= 1'b0;
      line_oe_n <= 1'b1;
      held_bit  <= 1'b0;
    end
    else if (!link.master_reset_n || standby)
    begin
      line_out  <= 1'b0;
      line_oe_n <= 1'b1;
      held_bit  <= 1'b0;
    end
    else if (gck_rise)
    begin
      if (!link.encode_env)
      begin
        line_out  <= 1'b0;
        line_oe_n <= 1'b1;
      end
      else if (link.shift_clk)
      begin
        held_bit  <= link.nrz_data;
        line_out  <= link.nrz_data;
        line_oe_n <= 1'b0;
      end
      else
      begin
        line_out  <= ~held_bit;
        line_oe_n <= 1'b0;
      end
    end
  end

  // ---------------- Decoder ----------------
  logic                                rx_meta;
  logic                                rx_sync;
  logic                                rx_last;
  manchester_pkg::rx_state_t           rx_state;
  logic [manchester_pkg::CNT_W-1:0]    rx_cnt;
  logic                                push_valid;
  logic                                push_bit;
  logic                                push_ready;
  logic                                rx_edge;

  // Line comes from the remote node: two flops before any use
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      rx_last <= 1'b0;
    end
    else
    begin
      rx_meta <= line_in;
      rx_sync <= rx_meta;
      rx_last <= rx_sync;
    end
  end

  assign rx_edge = rx_sync ^ rx_last;

  // Idle line is low, so the first rise is taken as a cell start
  // with a positive first half bit. Only edges late enough count as
  // mid-bit; cell-boundary edges fall inside the blanking window.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state   <= manchester_pkg::RX_HUNT;
      rx_cnt     <= '0;
      link.rx_env <= 1'b0;
      push_valid <= 1'b0;
      push_bit   <= 1'b0;
    end
    else
    begin
      push_valid <= 1'b0;
      if (!link.rx_strobe)
      begin
        rx_state    <= manchester_pkg::RX_HUNT;
        rx_cnt      <= '0;
        link.rx_env <= 1'b0;
      end
      else
      begin
        case (rx_state)
          manchester_pkg::RX_HUNT:
          begin
            link.rx_env <= 1'b0;
            if (rx_edge && rx_sync)
            begin
              rx_cnt   <= manchester_pkg::RX_START_CYC;
              rx_state <= manchester_pkg::RX_RUN;
            end
          end
          manchester_pkg::RX_RUN:
          begin
            if (rx_edge && rx_cnt >= manchester_pkg::RX_MID_MIN_CYC)
            begin
              push_valid  <= 1'b1;
              push_bit    <= rx_last;
              rx_cnt      <= '0;
              link.rx_env <= 1'b1;
            end
            else if (rx_cnt >= manchester_pkg::RX_TIMEOUT_CYC)
            begin
              link.rx_env <= 1'b0;
              rx_state    <= manchester_pkg::RX_HUNT;
            end
            else
              rx_cnt <= rx_cnt + 1'b1;
          end
          default:
            rx_state <= manchester_pkg::RX_HUNT;
        endcase
      end
    end
  end

  // ------------- Two-entry bit buffer -------------
  logic                         fifo_mem [manchester_pkg::FIFO_DEPTH];
  logic                         wr_ptr;
  logic                         rd_ptr;
  logic [1:0]                   fill;
  logic                         pop_valid;
  logic                         pop_ready;
  logic                         do_push;
  logic                         do_pop;

  assign push_ready = (fill != 2'(manchester_pkg::FIFO_DEPTH));
  assign pop_valid  = (fill != 2'h0);
  assign do_push    = push_valid & push_ready;
  assign do_pop     = pop_valid & pop_ready;

  always_ff @(posedge mclk)
  begin
    if (do_push)
      fifo_mem[wr_ptr] <= push_bit;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= ~wr_ptr;
      if (do_pop)
        rd_ptr <= ~rd_ptr;
      if (do_push && !do_pop)
        fill <= fill + 2'h1;
      else if (do_pop && !do_push)
        fill <= fill - 2'h1;
    end
  end

  // The line cannot be stalled; a long controller stall overflows
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rx_overrun <= 1'b0;
    else if (push_valid && !push_ready)
      rx_overrun <= 1'b1;
    else if (rx_state == manchester_pkg::RX_HUNT && rx_edge && rx_sync)
      rx_overrun <= 1'b0;
  end

  // ------------- Recovered clock generator -------------
  logic [manchester_pkg::CNT_W-1:0] out_cnt;
  logic                             out_busy;

  assign pop_ready = ~out_busy & link.rx_ready;

  // Data changes only while the clock is low, well before its rise
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_busy     <= 1'b0;
      out_cnt      <= '0;
      link.rx_clk  <= 1'b0;
      link.rx_data <= 1'b0;
    end
    else if (do_pop)
    begin
      out_busy     <= 1'b1;
      out_cnt      <= '0;
      link.rx_clk  <= 1'b0;
      link.rx_data <= fifo_mem[rd_ptr];
    end
    else if (out_busy)
    begin
      out_cnt <= out_cnt + 1'b1;
      if (out_cnt == manchester_pkg::RCLK_LOW_CYC - 1'b1)
        link.rx_clk <= 1'b1;
      if (out_cnt == manchester_pkg::RCLK_LOW_CYC
                     + manchester_pkg::RCLK_HIGH_CYC - 1'b1)
      begin
        link.rx_clk <= 1'b0;
        out_busy    <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// file: shared/manchester_pkg.sv
package manchester_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // Transmit cell timing as seen on the controller pins
  localparam int BIT_NS        = 100;
  localparam int EDGE1_NS      = 25;
  localparam int EDGE2_NS      = 75;
  localparam int GCK_HIGH_NS   = 20;
  localparam int SHIFT_HIGH_NS = 50;
  localparam int MRST_MAX_NS   = 15;

  // Receive side decision points, relative to the last mid-bit edge, then recovered clock low and high widths
  localparam int RX_MID_MIN_NS = 75;
  localparam int RX_TIMEOUT_NS = 125;
  localparam int RX_START_NS   = 50;
  localparam int RCLK_LOW_NS   = 40;
  localparam int RCLK_HIGH_NS  = 40;

  localparam int CNT_W = 6;

  // Least times round up, longest times round down
  localparam logic [CNT_W-1:0] BIT_CYC =
    CNT_W'(BIT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EDGE1_CYC =
    CNT_W'((EDGE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] EDGE2_CYC =
    CNT_W'((EDGE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GCK_HIGH_CYC =
    CNT_W'((GCK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SHIFT_HIGH_CYC =
    CNT_W'((SHIFT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MRST_CYC =
    CNT_W'(MRST_MAX_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RX_MID_MIN_CYC =
    CNT_W'((RX_MID_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RX_TIMEOUT_CYC =
    CNT_W'(RX_TIMEOUT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RX_START_CYC =
    CNT_W'(RX_START_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RCLK_LOW_CYC =
    CNT_W'((RCLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RCLK_HIGH_CYC =
    CNT_W'((RCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_RUN
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND,
    TX_TAIL
  } tx_state_t;

endpackage

// file: shared/manchester_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface manchester_link_if;
  logic shift_clk;
  logic gated_clk;
  logic nrz_data;
  logic encode_env;
  logic encoder_enable;
  logic power_mgmt;
  logic master_reset_n;
  logic rx_strobe;
  logic rx_ready;
  logic rx_data;
  logic rx_clk;
  logic rx_env;

  modport device_end (
    input  shift_clk,
    input  gated_clk,
    input  nrz_data,
    input  encode_env,
    input  encoder_enable,
    input  power_mgmt,
    input  master_reset_n,
    input  rx_strobe,
    input  rx_ready,
    output rx_data,
    output rx_clk,
    output rx_env
  );

  modport ctrl_end (
    output shift_clk,
    output gated_clk,
    output nrz_data,
    output encode_env,
    output encoder_enable,
    output power_mgmt,
    output master_reset_n,
    output rx_strobe,
    output rx_ready,
    input  rx_data,
    input  rx_clk,
    input  rx_env
  );
endinterface

`default_nettype wire

// file: rtl/manchester_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module manchester_ctrl (
  input  wire logic             mclk,
  input  wire logic             resetn,
  manchester_link_if.ctrl_end   link,
  input  wire logic             tx_valid,
  input  wire logic             tx_bit,
  input  wire logic             tx_last,
  output logic                  tx_ready,
  input  wire logic             power_up,
  input  wire logic             encoder_reset,
  input  wire logic             rx_enable,
  input  wire logic             rx_stall,
  output logic                  rx_bit,
  output logic                  rx_bit_valid,
  output logic                  rx_active
);

  manchester_pkg::tx_state_t         state;
  logic [manchester_pkg::CNT_W-1:0]  cc;
  logic                              last_q;
  logic [manchester_pkg::CNT_W-1:0]  mrst_cnt;
  logic                              rclk_prev;
  logic                              take;

  assign take = tx_valid & ~tx_ready;

  function automatic logic in_pulse(
    input logic [manchester_pkg::CNT_W-1:0] c,
    input logic [manchester_pkg::CNT_W-1:0] start);
    in_pulse = (c >= start) && (c < start + manchester_pkg::GCK_HIGH_CYC);
  endfunction

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state           <= manchester_pkg::TX_IDLE;
      cc              <= '0;
      last_q          <= 1'b0;
      tx_ready        <= 1'b0;
      link.nrz_data   <= 1'b0;
      link.encode_env <= 1'b0;
    end
    else
    begin
      tx_ready <= 1'b0;
      case (state)
        manchester_pkg::TX_IDLE:
        begin
          cc <= '0;
          if (take && (power_up || link.encoder_enable))
          begin
            tx_ready        <= 1'b1;
            link.nrz_data   <= tx_bit;
            last_q          <= tx_last;
            link.encode_env <= 1'b1;
            state           <= manchester_pkg::TX_SEND;
          end
        end
        manchester_pkg::TX_SEND:
        begin
          if (cc == manchester_pkg::BIT_CYC - 1'b1)
          begin
            cc <= '0;
            if (!last_q && take)
            begin
              tx_ready      <= 1'b1;
              link.nrz_data <= tx_bit;
              last_q        <= tx_last;
            end
            else
            begin
              link.encode_env <= 1'b0;
              state           <= manchester_pkg::TX_TAIL;
            end
          end
          else
            cc <= cc + 1'b1;
        end
        manchester_pkg::TX_TAIL:
        begin
          cc <= cc + 1'b1;
          if (cc == manchester_pkg::EDGE1_CYC
                    + manchester_pkg::GCK_HIGH_CYC)
            state <= manchester_pkg::TX_IDLE;
        end
        default:
          state <= manchester_pkg::TX_IDLE;
      endcase
    end
  end

  // Clocks follow the cell counter with one cycle of lag
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.shift_clk <= 1'b0;
      link.gated_clk <= 1'b0;
    end
    else
    begin
      link.shift_clk <= (state == manchester_pkg::TX_SEND)
                        && (cc < manchester_pkg::SHIFT_HIGH_CYC);
      link.gated_clk <= ((state == manchester_pkg::TX_SEND)
                         && (in_pulse(cc, manchester_pkg::EDGE1_CYC)
                          || in_pulse(cc, manchester_pkg::EDGE2_CYC)))
                     || ((state == manchester_pkg::TX_TAIL)
                         && in_pulse(cc, manchester_pkg::EDGE1_CYC));
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.encoder_enable <= 1'b0;
      link.power_mgmt     <= 1'b0;
      link.rx_strobe      <= 1'b0;
      link.rx_ready       <= 1'b0;
    end
    else
    begin
      link.encoder_enable <= (state != manchester_pkg::TX_IDLE) || tx_valid;
      link.power_mgmt     <= power_up;
      link.rx_strobe      <= rx_enable;
      link.rx_ready       <= ~rx_stall;
    end
  end

  // Reset pulse kept within its longest allowed width
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mrst_cnt            <= '0;
      link.master_reset_n <= 1'b1;
    end
    else if (encoder_reset && mrst_cnt == '0 && link.master_reset_n)
    begin
      mrst_cnt            <= manchester_pkg::MRST_CYC - 1'b1;
      link.master_reset_n <= 1'b0;
    end
    else if (mrst_cnt != '0)
      mrst_cnt <= mrst_cnt - 1'b1;
    else
      link.master_reset_n <= 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rclk_prev    <= 1'b0;
      rx_bit       <= 1'b0;
      rx_bit_valid <= 1'b0;
      rx_active    <= 1'b0;
    end
    else
    begin
      rclk_prev    <= link.rx_clk;
      rx_bit_valid <= link.rx_clk & ~rclk_prev;
      rx_active    <= link.rx_env;
      if (link.rx_clk && !rclk_prev)
        rx_bit <= link.rx_data;
    end
  end

endmodule

`default_nettype wire

// file: test/manchester_chk.sv
`timescale 1ns/1ps
`default_nettype none

module manchester_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic shift_clk,
  input wire logic gated_clk,
  input wire logic nrz_data,
  input wire logic encode_env,
  input wire logic encoder_enable,
  input wire logic power_mgmt,
  input wire logic master_reset_n,
  input wire logic rx_strobe,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic rx_env,
  input wire logic line_out,
  input wire logic line_oe_n,
  input wire logic tx_standby
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  logic tx_powered;
  logic tx_live;
  logic line_idle;

  // Judged from the power inputs, not the flag that lags them
  assign tx_powered = encoder_enable || power_mgmt;
  assign tx_live    = master_reset_n && tx_powered;
  assign line_idle  = line_oe_n && !line_out;

  sequence first_edge;
    $rose(gated_clk) && tx_live && shift_clk && encode_env;
  endsequence
  sequence second_edge;
    $rose(gated_clk) && tx_live && !shift_clk && encode_env;
  endsequence
  sequence tail_edge;
    $rose(gated_clk) && tx_live && !encode_env;
  endsequence
  sequence shift_high_run;
    shift_clk [*8] ##1 shift_clk [*5] ##1 !shift_clk;
  endsequence
  sequence gck_high_run;
    gated_clk [*5] ##1 !gated_clk;
  endsequence
  sequence cell_edges;
    $rose(gated_clk) ##12 $rose(gated_clk);
  endsequence
  sequence rclk_high_run;
    rx_clk [*8] ##1 rx_clk ##1 !rx_clk;
  endsequence
  sequence mrst_pulse;
    !master_reset_n [*3] ##1 master_reset_n;
  endsequence

  chk_strobe_off_env: assert property (!rx_strobe [*2] |-> !rx_env)
    else $error("envelope high with receiver disabled");
  chk_standby_level: assert property (tx_standby == !$past(tx_powered))
    else $error("standby does not follow power inputs");
  chk_standby_idle: assert property (tx_standby [*2] |-> line_idle)
    else $error("line driven in standby");
  chk_first_half: assert property (first_edge |=>
    !line_oe_n && line_out == $past(nrz_data))
    else $error("first half level wrong");
  chk_second_half: assert property (second_edge |=>
    !line_oe_n && line_out == !$past(nrz_data))
    else $error("second half level wrong");
  chk_tail_idle: assert property (tail_edge |=> line_idle)
    else $error("line not idle after closing edge");
  chk_shift_width: assert property ($rose(shift_clk) |-> shift_high_run)
    else $error("shift clock high time wrong");
  chk_cell_edges: assert property ($rose(shift_clk) |-> ##7 cell_edges)
    else $error("gated clock edges misplaced in cell");
  chk_gck_width: assert property ($rose(gated_clk) |-> gck_high_run)
    else $error("gated clock pulse width wrong");
  chk_env_first: assert property (
    $fell(encode_env) |-> ##8 $rose(gated_clk))
    else $error("closing edge missing after envelope fall");
  chk_rclk_width: assert property ($rose(rx_clk) |=> rclk_high_run)
    else $error("recovered clock pulse width wrong");
  chk_data_stable: assert property (rx_clk |-> $stable(rx_data))
    else $error("recovered data moved while clock high");
  chk_mrst_width: assert property ($fell(master_reset_n) |-> mrst_pulse)
    else $error("encoder reset pulse width wrong");
  chk_mrst_idle: assert property (!master_reset_n [*2] |-> line_oe_n)
    else $error("line driven during encoder reset");
endmodule

`default_nettype wire

// file: test/manchester_serial_codec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module manchester_serial_codec_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_bit = 1'b0;
  logic tx_last = 1'b0;
  logic power_up = 1'b0;
  logic encoder_reset = 1'b0;
  logic rx_enable = 1'b0;
  logic rx_stall = 1'b0;
  logic line_in;
  logic line_out, line_oe_n, tx_standby, rx_overrun;
  logic tx_ready, rx_bit, rx_bit_valid, rx_active;
  logic rx_q[$];
  logic env_seen = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] w;

  manchester_link_if link ();

  // Released line sits at its pull-down level
  assign line_in = line_oe_n ? 1'b0 : line_out;

  always #2 mclk = ~mclk;

  manchester_codec manchester_codec_i (.mclk(mclk), .resetn(resetn),
    .link(link), .line_in(line_in), .line_out(line_out),
    .line_oe_n(line_oe_n), .tx_standby(tx_standby),
    .rx_overrun(rx_overrun));

  manchester_ctrl manchester_ctrl_i (.mclk(mclk), .resetn(resetn),
    .link(link), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_last(tx_last), .tx_ready(tx_ready), .power_up(power_up),
    .encoder_reset(encoder_reset), .rx_enable(rx_enable),
    .rx_stall(rx_stall), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .rx_active(rx_active));

  manchester_chk manchester_chk_i (.mclk(mclk), .resetn(resetn),
    .shift_clk(link.shift_clk), .gated_clk(link.gated_clk),
    .nrz_data(link.nrz_data), .encode_env(link.encode_env),
    .encoder_enable(link.encoder_enable), .power_mgmt(link.power_mgmt),
    .master_reset_n(link.master_reset_n), .rx_strobe(link.rx_strobe),
    .rx_clk(link.rx_clk), .rx_data(link.rx_data), .rx_env(link.rx_env),
    .line_out(line_out), .line_oe_n(line_oe_n), .tx_standby(tx_standby));

  always @(posedge mclk)
  begin
    if (rx_bit_valid === 1'b1)
      rx_q.push_back(rx_bit);
    if (rx_active === 1'b1)
      env_seen = 1'b1;
  end

  function automatic logic exp_standby(input logic pu);
    // Idle controller keeps encoder enable low
    return !pu;
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bit 0 of the word goes out first
  task automatic send_word(input logic [7:0] wd, input int len);
    int k;
    int t;
    for (k = 0; k < len; k++)
    begin
      tx_valid <= 1'b1;
      tx_bit <= wd[k];
      tx_last <= (k == len - 1);
      t = 0;
      do
      begin
        @(posedge mclk);
        t++;
      end while (tx_ready !== 1'b1 && t < 100);
      if (t >= 100)
        check("tx take", 8'h00, 8'h01);
    end
    tx_valid <= 1'b0;
  endtask

  task automatic run_word(input logic [7:0] wd, input int len,
                          input logic en);
    int k;
    rx_q.delete();
    env_seen = 1'b0;
    send_word(wd, len);
    repeat (160) @(posedge mclk);
    check("rx_active", {7'h00, rx_active}, 8'h00);
    check("env seen", {7'h00, env_seen}, {7'h00, en});
    check("bit count", 8'(rx_q.size()), en ? 8'(len) : 8'h00);
    if (en)
      for (k = 0; k < rx_q.size(); k++)
        check("rx bit", {7'h00, rx_q[k]}, {7'h00, wd[k]});
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h9937EC8B));
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    for (int p = 0; p < 3; p++)
    begin
      power_up <= p[0];
      repeat (4) @(posedge mclk);
      check("standby", {7'h00, tx_standby},
            {7'h00, exp_standby(p[0])});
    end
    power_up <= 1'b0;
    rx_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    run_word(8'hFF, 8, 1'b1);
    run_word(8'h01, 8, 1'b1);
    run_word(8'h01, 1, 1'b1);
    repeat (6)
    begin
      n = $urandom_range(1, 8);
      // Decoder locks only on a leading one
      w = 8'($urandom()) | 8'h01;
      power_up <= 1'($urandom_range(0, 1));
      run_word(w, n, 1'b1);
    end
    rx_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    run_word(8'h2D, 6, 1'b0);
    rx_enable <= 1'b1;
    rx_stall <= 1'b1;
    repeat (4) @(posedge mclk);
    rx_q.delete();
    send_word(8'h0D, 4);
    repeat (160) @(posedge mclk);
    check("overrun", {7'h00, rx_overrun}, 8'h01);
    check("stalled count", 8'(rx_q.size()), 8'h00);
    rx_stall <= 1'b0;
    repeat (80) @(posedge mclk);
    check("drained count", 8'(rx_q.size()), 8'h02);
    check("drained first", {7'h00, rx_q[0]}, 8'h01);
    check("drained second", {7'h00, rx_q[1]}, 8'h00);
    fork
      send_word(8'h07, 3);
      begin
        @(posedge mclk iff tx_ready === 1'b1);
        // Strike after the second half edge, before the next cell
        repeat (20) @(posedge mclk);
        encoder_reset <= 1'b1;
        @(posedge mclk);
        encoder_reset <= 1'b0;
        repeat (3) @(posedge mclk);
        check("reset idle", {7'h00, line_oe_n}, 8'h01);
      end
    join
    repeat (200) @(posedge mclk);
    end_sim();
  end
endmodule

`default_nettype wire
